// >>> gpsm_map.svh
// Purpose: Register map and constants of the gigabit status and indirect access block
// Assumes: Classic Wishbone, 32-bit data, word aligned registers
// Notes:   Offsets are register indices; byte address is four times the index
`ifndef GPSM_MAP_SVH
`define GPSM_MAP_SVH

// ****************************************
// Register indices
// ****************************************
`define GPSM_IDX_LINK_STATUS   5'h0a
`define GPSM_IDX_SETUP         5'h0d
`define GPSM_IDX_DATA          5'h0e
`define GPSM_IDX_IRQ_STATUS    5'h18
`define GPSM_IDX_IRQ_MASK      5'h19

// ****************************************
// Field positions
// ****************************************
`define GPSM_ST_FAULT_BIT      15
`define GPSM_ST_MASTER_BIT     14
`define GPSM_ST_LOCAL_BIT      13
`define GPSM_ST_REMOTE_BIT     12
`define GPSM_ST_LP_FD_BIT      11
`define GPSM_ST_LP_HD_BIT      10
`define GPSM_SETUP_MODE_HI     15
`define GPSM_SETUP_MODE_LO     14
`define GPSM_SETUP_DEV_HI      4
`define GPSM_SETUP_DEV_LO      0

// ****************************************
// Reset values and limits
// ****************************************
`define GPSM_ZERO16            16'h0000
`define GPSM_IDLE_ERR_RESET    8'h00
`define GPSM_IDLE_ERR_MAX      8'hff
`define GPSM_IRQ_RESET         3'h0
`define GPSM_MMD_DEVS          32
`define GPSM_MMD_REGS          8
`define GPSM_MMD_REG_BITS      3

`endif

// >>> gpsm_pkg.sv
// Purpose: Types of the gigabit status and indirect access block
// Assumes: Used by qualified names only
// Notes:   None
package gpsm_pkg;
  typedef enum logic [1:0] {
    GPSM_MODE_INDEX   = 2'b00,
    GPSM_MODE_DATA    = 2'b01,
    GPSM_MODE_INC_RW  = 2'b10,
    GPSM_MODE_INC_WR  = 2'b11
  } gpsm_mode_t;

  typedef enum logic [1:0] {
    GPSM_BUS_IDLE = 2'b00,
    GPSM_BUS_ACK  = 2'b01
  } gpsm_bus_t;
endpackage : gpsm_pkg

// >>> gpsm_mmd_store.sv
// Purpose: Register array behind the indirect access data port
// Assumes: One access per cycle, write data and address stable with the strobe
// Notes:   Small array stands in for real MMD registers; reads are combinational
`timescale 1ns/1ns
`include "gpsm_map.svh"

module gpsm_mmd_store (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // Access port
  input  wire logic [4:0]  dev_in,
  input  wire logic [15:0] index_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);

  logic [15:0] mem_r   [`GPSM_MMD_DEVS*`GPSM_MMD_REGS];
  logic [15:0] mem_nxt [`GPSM_MMD_DEVS*`GPSM_MMD_REGS];
  logic [7:0]  slot;

  // Only low index bits select a slot; higher indices alias
  assign slot      = {dev_in, index_in[`GPSM_MMD_REG_BITS-1:0]};
  assign rdata_out = mem_r[slot];

  always_comb
  begin
    mem_nxt = mem_r;
    if (wr_in)
    begin
      mem_nxt[slot] = wdata_in;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < `GPSM_MMD_DEVS*`GPSM_MMD_REGS; i++)
      begin
        mem_r[i] <= `GPSM_ZERO16;
      end
    end
    else
    begin
      mem_r <= mem_nxt;
    end
  end

endmodule : gpsm_mmd_store

// >>> gpsm_top.sv
// Purpose: Gigabit link status register and indirect MMD access over Wishbone
// Assumes: Status inputs come from another clock domain and are synchronised here
// Notes:   Idle error strobe is one pulse per symbol period with error
`timescale 1ns/1ns
`include "gpsm_map.svh"

// Function
// R1 - Fault bit 15 latches high on a fault, clears on status read.
// R2 - Bit 14 shows master resolution: one master, zero slave.
// R3 - Bit 13 shows local receiver OK.
// R4 - Bit 12 shows remote receiver OK.
// R5 - Bits 11 and 10 show partner full and half duplex capability.
// R6 - Bits 7:0 count idle errors under idle-reception condition, reset zero.
// R7 - Counter adds one per symbol period with receive error.
// R8 - Counter clears on status read and saturates at maximum.
// R9 - Setup bits 15:14 select index or data modes with increments.
// R10 - Setup bits 4:0 hold device address; both fields reset zero.
// R11 - Mode 00: data register accesses the stored register index.
// R12 - Data modes access selected MMD register; index advances per mode.
// R13 - Host sets mode 00, writes index, selects data mode, then accesses.
module gpsm_top (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [6:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Link status from the PCS
  input  wire logic        ms_fault_in,
  input  wire logic        ms_master_in,
  input  wire logic        local_rx_ok_in,
  input  wire logic        remote_rx_ok_in,
  input  wire logic        lp_full_duplex_in,
  input  wire logic        lp_half_duplex_in,
  input  wire logic        idle_rx_in,
  input  wire logic        idle_err_in,
  // Interrupt
  output logic             irq_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync2_d_r;
  logic [NSYNC-1:0] sync1_nxt;
  logic [NSYNC-1:0] sync2_nxt;

  assign raw_in = {idle_err_in, idle_rx_in, lp_half_duplex_in, lp_full_duplex_in,
                   remote_rx_ok_in, local_rx_ok_in, ms_master_in, ms_fault_in};

  always_comb
  begin
    sync1_nxt = raw_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync1_r   <= 8'h00;
      sync2_r   <= 8'h00;
      sync2_d_r <= 8'h00;
    end
    else
    begin
      sync1_r   <= sync1_nxt;
      sync2_r   <= sync2_nxt;
      sync2_d_r <= sync2_r;
    end
  end

  logic fault_rise;
  logic err_rise;
  logic err_ok;
  // Edges so a long event pulse counts once
  assign fault_rise = sync2_r[0] & ~sync2_d_r[0];
  assign err_rise   = sync2_r[7] & ~sync2_d_r[7];
  // R6 idle-reception gate
  assign err_ok     = err_rise & sync2_r[6];

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [6:0] adr, input logic [4:0] idx);
    hit = (adr[6:2] == idx);
  endfunction : hit

  logic bus_req;
  logic bus_acc;
  logic bus_wr;
  logic bus_rd;
  gpsm_pkg::gpsm_bus_t bus_r;
  gpsm_pkg::gpsm_bus_t bus_nxt;

  assign bus_req = wb_cyc_in & wb_stb_in;
  // Access takes effect at the ack edge only
  assign bus_acc = bus_req & (bus_r == gpsm_pkg::GPSM_BUS_ACK);
  assign bus_wr  = bus_acc & wb_we_in;
  assign bus_rd  = bus_acc & ~wb_we_in;
  // Low half lanes carry the 16-bit registers
  logic wr_lo;
  logic wr_hi;
  assign wr_lo = bus_wr & wb_sel_in[0];
  assign wr_hi = bus_wr & wb_sel_in[1];

  always_comb
  begin
    case (bus_r)
      gpsm_pkg::GPSM_BUS_IDLE: bus_nxt = bus_req ? gpsm_pkg::GPSM_BUS_ACK
                                                 : gpsm_pkg::GPSM_BUS_IDLE;
      gpsm_pkg::GPSM_BUS_ACK:  bus_nxt = gpsm_pkg::GPSM_BUS_IDLE;
      default:                 bus_nxt = gpsm_pkg::GPSM_BUS_IDLE;
    endcase
  end

  // ****************************************
  // Status and counter
  // ****************************************
  logic       fault_r;
  logic       fault_nxt;
  logic [7:0] err_cnt_r;
  logic [7:0] err_cnt_nxt;
  logic       st_rd;
  logic [31:0] rdata_r;
  assign st_rd = bus_rd & hit(wb_adr_in, `GPSM_IDX_LINK_STATUS);

  always_comb
  begin
    // R1 latch; clear only what the read returned
    fault_nxt = fault_rise | (fault_r & ~(st_rd & rdata_r[`GPSM_ST_FAULT_BIT]));
    // R8 read clear; counts after capture survive
    err_cnt_nxt = st_rd ? (err_cnt_r - rdata_r[7:0]) : err_cnt_r;
    // R7 count, R8 saturate
    if (err_ok && err_cnt_nxt != `GPSM_IDLE_ERR_MAX)
    begin
      err_cnt_nxt = err_cnt_nxt + 8'h01;
    end
  end

  logic [15:0] status_word;
  always_comb
  begin
    status_word = `GPSM_ZERO16;
    // R1 fault bit
    status_word[`GPSM_ST_FAULT_BIT]  = fault_r;
    // R2 master resolution
    status_word[`GPSM_ST_MASTER_BIT] = sync2_r[1];
    // R3 local receiver
    status_word[`GPSM_ST_LOCAL_BIT]  = sync2_r[2];
    // R4 remote receiver
    status_word[`GPSM_ST_REMOTE_BIT] = sync2_r[3];
    // R5 partner abilities
    status_word[`GPSM_ST_LP_FD_BIT]  = sync2_r[4];
    status_word[`GPSM_ST_LP_HD_BIT]  = sync2_r[5];
    // R6 error count field
    status_word[7:0]                 = err_cnt_r;
  end

  // ****************************************
  // Indirect access
  // ****************************************
  logic [15:0] setup_r;
  logic [15:0] setup_nxt;
  logic [15:0] index_r;
  logic [15:0] index_nxt;
  logic [15:0] mmd_rdata;
  logic        dat_hit;
  logic        mmd_wr;
  logic [15:0] mmd_wdata;
  gpsm_pkg::gpsm_mode_t mode;

  assign mode    = gpsm_pkg::gpsm_mode_t'(setup_r[`GPSM_SETUP_MODE_HI:`GPSM_SETUP_MODE_LO]);
  assign dat_hit = hit(wb_adr_in, `GPSM_IDX_DATA);
  // R12 data write path
  assign mmd_wr    = bus_wr & dat_hit & (mode != gpsm_pkg::GPSM_MODE_INDEX);
  assign mmd_wdata = {wr_hi ? wb_dat_in[15:8] : mmd_rdata[15:8],
                      wr_lo ? wb_dat_in[7:0]  : mmd_rdata[7:0]};

  always_comb
  begin
    setup_nxt = setup_r;
    index_nxt = index_r;
    // R9 R10 setup fields
    if (hit(wb_adr_in, `GPSM_IDX_SETUP))
    begin
      if (wr_lo) setup_nxt[7:0]  = wb_dat_in[7:0];
      if (wr_hi) setup_nxt[15:8] = wb_dat_in[15:8];
    end
    if (bus_acc && dat_hit)
    begin
      case (mode)
        // R11 index access
        gpsm_pkg::GPSM_MODE_INDEX:
        begin
          if (wr_lo) index_nxt[7:0]  = wb_dat_in[7:0];
          if (wr_hi) index_nxt[15:8] = wb_dat_in[15:8];
        end
        // R12 increment on any access
        gpsm_pkg::GPSM_MODE_INC_RW: index_nxt = index_r + 16'h0001;
        // R12 increment on writes
        gpsm_pkg::GPSM_MODE_INC_WR:
          if (wb_we_in) index_nxt = index_r + 16'h0001;
        default: index_nxt = index_r;
      endcase
    end
  end

  gpsm_mmd_store u_store (
    .mclk_in   (mclk_in),
    .reset_in  (reset_in),
    .dev_in    (setup_r[`GPSM_SETUP_DEV_HI:`GPSM_SETUP_DEV_LO]),
    .index_in  (index_r),
    .wr_in     (mmd_wr),
    .wdata_in  (mmd_wdata),
    .rdata_out (mmd_rdata)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  // Events: fault, idle error, local receiver lost
  logic [2:0] irq_st_r;
  logic [2:0] irq_st_nxt;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_mask_nxt;
  logic [2:0] irq_ev;
  logic       rx_lost;
  assign rx_lost = ~sync2_r[2] & sync2_d_r[2];
  assign irq_ev  = {rx_lost, err_ok, fault_rise};

  always_comb
  begin
    irq_mask_nxt = irq_mask_r;
    if (wr_lo && hit(wb_adr_in, `GPSM_IDX_IRQ_MASK))
    begin
      irq_mask_nxt = wb_dat_in[2:0];
    end
    // Set wins over the read clear
    // Only bits the read returned are cleared, so late events are kept
    irq_st_nxt = irq_ev |
                 (irq_st_r & ~({3{bus_rd & hit(wb_adr_in, `GPSM_IDX_IRQ_STATUS)}} &
                               rdata_r[2:0]));
  end

  // ****************************************
  // Read mux and registers
  // ****************************************
  logic [31:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (bus_req && bus_r == gpsm_pkg::GPSM_BUS_IDLE)
    begin
      case (wb_adr_in[6:2])
        `GPSM_IDX_LINK_STATUS: rdata_nxt[15:0] = status_word;
        `GPSM_IDX_SETUP:       rdata_nxt[15:0] = setup_r;
        `GPSM_IDX_DATA:        rdata_nxt[15:0] =
          (mode == gpsm_pkg::GPSM_MODE_INDEX) ? index_r : mmd_rdata;
        `GPSM_IDX_IRQ_STATUS:  rdata_nxt[2:0]  = irq_st_r;
        `GPSM_IDX_IRQ_MASK:    rdata_nxt[2:0]  = irq_mask_r;
        // Unmapped reads return zero and still ack
        default:               rdata_nxt       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      bus_r      <= gpsm_pkg::GPSM_BUS_IDLE;
      fault_r    <= 1'b0;
      err_cnt_r  <= `GPSM_IDLE_ERR_RESET;
      setup_r    <= `GPSM_ZERO16;
      index_r    <= `GPSM_ZERO16;
      irq_st_r   <= `GPSM_IRQ_RESET;
      irq_mask_r <= `GPSM_IRQ_RESET;
      rdata_r    <= 32'h0000_0000;
    end
    else
    begin
      bus_r      <= bus_nxt;
      fault_r    <= fault_nxt;
      err_cnt_r  <= err_cnt_nxt;
      setup_r    <= setup_nxt;
      index_r    <= index_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign wb_ack_out = (bus_r == gpsm_pkg::GPSM_BUS_ACK) & bus_req;
  assign wb_dat_out = rdata_r;
  assign irq_out    = |(irq_st_r & irq_mask_r);

endmodule : gpsm_top

// >>> gpsm_top_asserts.sv
// Purpose: Port checks of gpsm_top
// Assumes: Inputs quiet eight cycles before a status read is judged
// Notes:   Reads that race the synchronisers are skipped, not judged
`timescale 1ns/1ns
module gpsm_top_asserts (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        reset_in,
  // Bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [6:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // Status
  input wire logic        ms_fault_in,
  input wire logic        ms_master_in,
  input wire logic        local_rx_ok_in,
  input wire logic        remote_rx_ok_in,
  input wire logic        lp_full_duplex_in,
  input wire logic        lp_half_duplex_in,
  input wire logic        idle_rx_in,
  input wire logic        idle_err_in
);
  logic [4:0] lv_r;
  logic [3:0] la_r, fa_r, ea_r;
  logic       f_r, e_r, fp_r;
  logic [7:0] ec_r;
  wire        st = wb_ack_out && !wb_we_in && wb_adr_in == 7'h28;
  wire        lq = st && la_r > 4'h7;
  wire        eq = st && ea_r > 4'h7;
  wire        fr = ms_fault_in && !f_r;
  wire        er = idle_err_in && !e_r && idle_rx_in;
  wire [4:0]  lv = {ms_master_in, local_rx_ok_in, remote_rx_ok_in,
                    lp_full_duplex_in, lp_half_duplex_in};
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // Ages saturate so a long quiet spell stays judged
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      {lv_r, la_r, fa_r, ea_r, f_r, e_r, fp_r, ec_r} <= '0;
    else
    begin
      lv_r <= lv;
      f_r  <= ms_fault_in;
      e_r  <= idle_err_in;
      la_r <= (lv != lv_r) ? 4'h0 : la_r + {3'h0, la_r != 4'hf};
      fa_r <= fr ? 4'h0 : fa_r + {3'h0, fa_r != 4'hf};
      ea_r <= (idle_err_in != e_r) ? 4'h0 : ea_r + {3'h0, ea_r != 4'hf};
      fp_r <= fr || (fp_r && !(st && wb_dat_out[15]));
      ec_r <= st ? 8'h00 : ec_r + {7'h0, er && ec_r != 8'hff};
    end
  end
  property p_fault; st && fa_r > 4'h7 |-> wb_dat_out[15] == fp_r; endproperty
  a_fault: assert property (p_fault) else $error("fault bit wrong");
  property p_master; lq |-> wb_dat_out[14] == ms_master_in; endproperty
  a_master: assert property (p_master) else $error("master bit wrong");
  property p_local; lq |-> wb_dat_out[13] == local_rx_ok_in; endproperty
  a_local: assert property (p_local) else $error("local bit wrong");
  property p_remote; lq |-> wb_dat_out[12] == remote_rx_ok_in; endproperty
  a_remote: assert property (p_remote) else $error("remote bit wrong");
  property p_lp; lq |-> wb_dat_out[11:10] == {lp_full_duplex_in, lp_half_duplex_in}; endproperty
  a_lp: assert property (p_lp) else $error("partner bits wrong");
  property p_count; eq |-> wb_dat_out[9:0] == {2'h0, ec_r}; endproperty
  a_count: assert property (p_count) else $error("count wrong");
  property p_sat; eq && ec_r == 8'hff |-> wb_dat_out[7:0] == 8'hff; endproperty
  a_sat: assert property (p_sat) else $error("count not held");
  property p_ack; $rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out ##1 !wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  c_fault: cover property (st && wb_dat_out[15]);
  c_sat: cover property (eq && wb_dat_out[7:0] == 8'hff);
  c_data: cover property (wb_ack_out && wb_we_in && wb_adr_in == 7'h38);
endmodule : gpsm_top_asserts

// >>> gpsm_rx_model.sv
// Purpose: Receive side stand-in for gpsm_top
// Assumes: Tasks are called right after a rising edge
// Notes:   Strobes last one cycle with one quiet cycle after
`timescale 1ns/1ns
module gpsm_rx_model (
  // Clock
  input  wire logic mclk_in,
  // Receive side status
  output logic      fault_out,
  output logic      idle_out,
  output logic      err_out
);
  initial {fault_out, idle_out, err_out} = 3'h0;
  task automatic pulse(input logic f, input int n);
    for (int i = 0; i < n; i++)
    begin
      fault_out <= f;
      err_out   <= !f;
      @(posedge mclk_in);
      {fault_out, err_out} <= 2'h0;
      @(posedge mclk_in);
    end
  endtask : pulse
  task automatic idle(input logic v);
    idle_out <= v;
    @(posedge mclk_in);
  endtask : idle
endmodule : gpsm_rx_model

// >>> gpsm_top_test.sv
// Purpose: Register test of gpsm_top over classic Wishbone
// Assumes: Status inputs reach the registers within three cycles
// Notes:   Twelve quiet cycles before a judged read leave margin over the latency
`timescale 1ns/1ns
module gpsm_top_test;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [6:0]  adr = 7'h00;
  logic [15:0] wd = 16'h0000;
  logic [3:0]  sel = 4'hf;
  logic [4:0]  lv = 5'h00;
  logic [4:0]  pv [3] = '{5'h15, 5'h0a, 5'h1f};
  logic [31:0] dat;
  logic [15:0] got;
  logic        ack, irq, flt, idl, err;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  always #25 mclk_in = ~mclk_in;
  gpsm_rx_model i_gpsm_rx_model (.mclk_in, .fault_out(flt), .idle_out(idl), .err_out(err));
  gpsm_top i_gpsm_top (
    .mclk_in, .reset_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in({16'h0000, wd}), .wb_dat_out(dat), .wb_ack_out(ack),
    .ms_fault_in(flt), .ms_master_in(lv[4]), .local_rx_ok_in(lv[3]),
    .remote_rx_ok_in(lv[2]), .lp_full_duplex_in(lv[1]), .lp_half_duplex_in(lv[0]),
    .idle_rx_in(idl), .idle_err_in(err), .irq_out(irq));
  task automatic complete_run;
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Ack is sampled at the rising edge, as the slave sees it
  task automatic wb(input logic w, input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    @(posedge mclk_in);
    while (ack !== 1'b1)
      @(posedge mclk_in);
    got = dat[15:0];
    cyc <= 1'b0;
  endtask : wb
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(got, e);
  endtask : rd
  task automatic irq_is(input logic e);
    @(negedge mclk_in);
    chk({15'h0000, irq}, {15'h0000, e});
  endtask : irq_is
  task automatic settle;
    repeat (12) @(posedge mclk_in);
  endtask : settle
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(7'h34, 16'h0000);
    rd(7'h38, 16'h0000);
    rd(7'h64, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      lv <= pv[i];
      settle();
      rd(7'h28, {1'b0, pv[i], 10'h000});
    end
    wb(1'b1, 7'h64, 16'h0007);
    i_gpsm_rx_model.pulse(1'b1, 1);
    settle();
    irq_is(1'b1);
    rd(7'h28, 16'hfc00);
    rd(7'h28, 16'h7c00);
    rd(7'h60, 16'h0001);
    irq_is(1'b0);
    wb(1'b1, 7'h64, 16'h0003);
    lv <= 5'h17;
    settle();
    irq_is(1'b0);
    rd(7'h60, 16'h0004);
    wb(1'b1, 7'h64, 16'h0002);
    i_gpsm_rx_model.pulse(1'b0, 2);
    settle();
    rd(7'h28, 16'h5c00);
    i_gpsm_rx_model.idle(1'b1);
    settle();
    i_gpsm_rx_model.pulse(1'b0, 3);
    settle();
    irq_is(1'b1);
    rd(7'h28, 16'h5c03);
    rd(7'h28, 16'h5c00);
    rd(7'h60, 16'h0002);
    i_gpsm_rx_model.pulse(1'b0, 260);
    settle();
    rd(7'h28, 16'h5cff);
    wb(1'b1, 7'h34, 16'h3fe3);
    rd(7'h34, 16'h3fe3);
    wb(1'b1, 7'h38, 16'h0002);
    rd(7'h38, 16'h0002);
    wb(1'b1, 7'h34, 16'h8003);
    wb(1'b1, 7'h38, 16'ha0a0);
    wb(1'b1, 7'h38, 16'ha1a1);
    rd(7'h38, 16'h0000);
    wb(1'b1, 7'h34, 16'h0003);
    rd(7'h38, 16'h0005);
    wb(1'b1, 7'h38, 16'h0002);
    wb(1'b1, 7'h34, 16'hc003);
    rd(7'h38, 16'ha0a0);
    rd(7'h38, 16'ha0a0);
    wb(1'b1, 7'h38, 16'hb0b0);
    rd(7'h38, 16'ha1a1);
    wb(1'b1, 7'h34, 16'h4003);
    wb(1'b1, 7'h38, 16'hc3c3);
    rd(7'h38, 16'hc3c3);
    wb(1'b1, 7'h34, 16'h0004);
    wb(1'b1, 7'h38, 16'h0003);
    wb(1'b1, 7'h34, 16'h4004);
    rd(7'h38, 16'h0000);
    wb(1'b1, 7'h34, 16'h0003);
    rd(7'h38, 16'h0003);
    wb(1'b1, 7'h10, 16'hffff);
    rd(7'h10, 16'h0000);
    // Byte lanes: each select writes its own byte only
    sel <= 4'h2;
    wb(1'b1, 7'h34, 16'h40ff);
    sel <= 4'h1;
    wb(1'b1, 7'h34, 16'h0012);
    wb(1'b1, 7'h38, 16'h5a5a);
    sel <= 4'hf;
    rd(7'h34, 16'h4012);
    rd(7'h38, 16'h005a);
    complete_run();
  end
endmodule : gpsm_top_test
bind gpsm_top gpsm_top_asserts i_gpsm_top_asserts (.mclk_in, .reset_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .ms_fault_in, .ms_master_in, .local_rx_ok_in,
  .remote_rx_ok_in, .lp_full_duplex_in, .lp_half_duplex_in, .idle_rx_in, .idle_err_in);
